// File: rcfg_pkg.sv
package rcfg_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_RESET_ORIGIN = 12'h05c;
   localparam logic [11:0] OFS_RUN_CLOCK    = 12'h060;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ORIGIN_MSB  = 5;
   localparam int ACG_BIT     = 27;
   localparam int SYSTEM_DIVISOR_FIELD_MSB  = 26;
   localparam int SYSTEM_DIVISOR_FIELD_LSB  = 23;
   localparam int USEDIV_BIT  = 22;
   localparam int PLL_POWER_DOWN_BIT_BIT   = 13;
   localparam int OEN_BIT     = 12;
   localparam int BYPASS_BIT  = 11;
   localparam int OSC_MSB     = 5;
   localparam int OSC_LSB     = 4;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic       ACG_RST       = 1'b0;
   localparam logic [3:0] SYSTEM_DIVISOR_FIELD_RST    = 4'hf;
   localparam logic       USEDIV_RST    = 1'b0;
   localparam logic       PLL_POWER_DOWN_BIT_RST     = 1'b1;
   localparam logic       OEN_RST       = 1'b1;
   localparam logic       BYPASS_RST    = 1'b1;
   localparam logic [1:0] OSC_RST       = 2'h0;
   localparam logic [5:0] ORIGIN_PIN    = 6'h01;
   localparam logic [5:0] ORIGIN_POWER  = 6'h02;
   localparam logic [3:0] MIN_DIV_DFLT  = 4'h9;

   // ----------------------------------------------------------------
   // Oscillator source codes and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] OSC_MAIN      = 2'h0;
   localparam logic [1:0] OSC_INTERNAL  = 2'h1;
   localparam logic [1:0] OSC_INT_QTR   = 2'h2;
   localparam logic [1:0] OSC_RESERVED  = 2'h3;
   localparam int         PLL_OUT_MHZ   = 200;
   localparam int         PCLK_MHZ      = 25;
   localparam logic [4:0] DIV_RATIO_OFS = 5'h01;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic regulator_power_loss_flag;
      logic software_reset_flag;
      logic watchdog_reset_flag;
      logic brownout_reset_flag;
      logic poweron_reset_flag;
      logic pin_reset_flag;
   } rcfg_cause_t;

   typedef enum logic [1:0] {RCFG_RUN, RCFG_SLEEP, RCFG_DEEP} rcfg_mode_t;

   typedef enum logic {RCFG_PH_CAPTURE, RCFG_PH_RUN} rcfg_phase_t;

   typedef struct packed {
      logic       pll_power_down;
      logic       pll_out_en;
      logic       sys_from_pll;
      logic       div_used;
      logic [3:0] div_code;
      logic [1:0] osc_sel;
   } rcfg_clk_t;

endpackage

// File: rcfg_div_tick.sv
`timescale 1ns/100ps

module rcfg_div_tick (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Divide control.
   input  wire logic       enable,
   input  wire logic [4:0] ratio,
   // One-cycle enable pulse.
   output logic            tick
);

   logic [4:0] count_r;
   logic       tick_r;

   // Undivided, the pulse stands every cycle; divided, once per ratio cycles.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= 5'h00;
         tick_r  <= 1'b0;
      end else if (!enable) begin
         count_r <= 5'h00;
         tick_r  <= 1'b1;
      end else if (count_r >= ratio - 5'h01) begin
         count_r <= 5'h00;
         tick_r  <= 1'b1;
      end else begin
         count_r <= count_r + 5'h01;
         tick_r  <= 1'b0;
      end
   end

   assign tick = tick_r;

endmodule // rcfg_div_tick

// File: rcfg_ctrl.sv
`timescale 1ns/100ps


module rcfg_ctrl #(
   parameter logic [3:0] MIN_DIV_CODE = rcfg_pkg::MIN_DIV_DFLT
) (
   // Clock and reset.
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave.
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Reset controller and power manager.
   input  rcfg_pkg::rcfg_cause_t     reset_cause,
   input  rcfg_pkg::rcfg_mode_t      power_mode,
   // Clock-tree controls.
   output rcfg_pkg::rcfg_clk_t       clk_cfg,
   output rcfg_pkg::rcfg_mode_t      gating_select,
   output logic                      osc_pll_src_ok,
   output logic                      sys_clk_en
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   rcfg_pkg::rcfg_phase_t phase_r;
   logic [5:0]            origin_r;
   logic                  acg_r;
   logic [3:0]            system_divisor_field_r;
   logic                  usediv_r;
   logic                  pll_power_down_bit_r;
   logic                  oen_r;
   logic                  bypass_r;
   logic [1:0]            osc_r;
   logic [31:0]           prdata_r;
   rcfg_pkg::rcfg_clk_t   clk_cfg_r;
   rcfg_pkg::rcfg_mode_t  gating_r;
   logic                  osc_ok_r;
   logic [5:0]            cause_bits;
   logic [31:0]           read_word;
   logic                  hit_origin;
   logic                  hit_clock;
   logic                  access;
   logic                  wr_origin;
   logic                  wr_clock;
   logic                  pll_path;
   logic [3:0]            div_nxt;
   logic [4:0]            ratio;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------

   // The slave never stalls, so every access phase completes at once.
   assign hit_origin = (paddr == rcfg_pkg::OFS_RESET_ORIGIN);
   assign hit_clock  = (paddr == rcfg_pkg::OFS_RUN_CLOCK);
   assign access     = psel && penable;
   assign wr_origin  = access && pwrite && hit_origin;
   assign wr_clock   = access && pwrite && hit_clock;
   assign pready     = 1'b1;
   assign pslverr    = access && !hit_origin && !hit_clock; // Unmapped or unaligned.
   assign prdata     = prdata_r;

   // Reserved bits read as zero; no flop exists behind them.
   always_comb begin
      read_word = 32'h0000_0000;
      if (hit_origin) begin
         read_word[rcfg_pkg::ORIGIN_MSB:0] = origin_r;
      end else if (hit_clock) begin
         read_word[rcfg_pkg::ACG_BIT]                          = acg_r;
         read_word[rcfg_pkg::SYSTEM_DIVISOR_FIELD_MSB:rcfg_pkg::SYSTEM_DIVISOR_FIELD_LSB] = system_divisor_field_r;
         read_word[rcfg_pkg::USEDIV_BIT]                       = usediv_r;
         read_word[rcfg_pkg::PLL_POWER_DOWN_BIT_BIT]                        = pll_power_down_bit_r;
         read_word[rcfg_pkg::OEN_BIT]                          = oen_r;
         read_word[rcfg_pkg::BYPASS_BIT]                       = bypass_r;
         read_word[rcfg_pkg::OSC_MSB:rcfg_pkg::OSC_LSB]        = osc_r;
      end
   end

   // Read data is caught in the setup cycle so that it leaves a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= read_word;
      end
   end

   // ----------------------------------------------------------------
   // Reset origin flags
   // ----------------------------------------------------------------

   // The flags must outlive a reset, so they have no reset of their own;
   // a one-shot phase catches the cause at the first edge after release.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= rcfg_pkg::RCFG_PH_CAPTURE;
      end else begin
         case (phase_r)
            rcfg_pkg::RCFG_PH_CAPTURE: phase_r <= rcfg_pkg::RCFG_PH_RUN;
            rcfg_pkg::RCFG_PH_RUN:     phase_r <= rcfg_pkg::RCFG_PH_RUN;
            default:                   phase_r <= rcfg_pkg::RCFG_PH_RUN;
         endcase
      end
   end

   assign cause_bits = reset_cause;

   // Only a pin reset wipes the history; every other cause, power-on too,
   // is added. The limit: a first start must carry the pin cause, or the
   // flags that no cause names stay unknown until software writes them.
   always_ff @(posedge pclk) begin
      if (phase_r == rcfg_pkg::RCFG_PH_CAPTURE) begin
         if (reset_cause.pin_reset_flag) begin
            origin_r <= rcfg_pkg::ORIGIN_PIN;
         end else begin
            origin_r <= origin_r | cause_bits;
         end
      end else if (wr_origin) begin
         origin_r <= pwdata[rcfg_pkg::ORIGIN_MSB:0];
      end
   end

   // ----------------------------------------------------------------
   // Run clock setup register
   // ----------------------------------------------------------------

   // Only documented fields hold flops; writes to reserved bits vanish.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acg_r    <= rcfg_pkg::ACG_RST;
         system_divisor_field_r <= rcfg_pkg::SYSTEM_DIVISOR_FIELD_RST;
         usediv_r <= rcfg_pkg::USEDIV_RST;
         pll_power_down_bit_r  <= rcfg_pkg::PLL_POWER_DOWN_BIT_RST;
         oen_r    <= rcfg_pkg::OEN_RST;
         bypass_r <= rcfg_pkg::BYPASS_RST;
      end else if (wr_clock) begin
         acg_r    <= pwdata[rcfg_pkg::ACG_BIT];
         system_divisor_field_r <= pwdata[rcfg_pkg::SYSTEM_DIVISOR_FIELD_MSB:rcfg_pkg::SYSTEM_DIVISOR_FIELD_LSB];
         usediv_r <= pwdata[rcfg_pkg::USEDIV_BIT];
         pll_power_down_bit_r  <= pwdata[rcfg_pkg::PLL_POWER_DOWN_BIT_BIT];
         oen_r    <= pwdata[rcfg_pkg::OEN_BIT];
         bypass_r <= pwdata[rcfg_pkg::BYPASS_BIT];
      end
   end

   // The reserved source code is refused so the mux never sees it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_r <= rcfg_pkg::OSC_RST;
      end else if (wr_clock &&
                   pwdata[rcfg_pkg::OSC_MSB:rcfg_pkg::OSC_LSB] != rcfg_pkg::OSC_RESERVED) begin
         osc_r <= pwdata[rcfg_pkg::OSC_MSB:rcfg_pkg::OSC_LSB];
      end
   end

   // ----------------------------------------------------------------
   // Clock-tree controls
   // ----------------------------------------------------------------

   // Reserved low codes are clamped only on the PLL path; an oscillator
   // path keeps the code so software reads back what it wrote.
   assign pll_path = !bypass_r;
   assign div_nxt  = (pll_path && system_divisor_field_r < MIN_DIV_CODE) ? MIN_DIV_CODE : system_divisor_field_r;

   // Controls leave flops one cycle after the register changes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_cfg_r.pll_power_down <= rcfg_pkg::PLL_POWER_DOWN_BIT_RST;
         clk_cfg_r.pll_out_en     <= !rcfg_pkg::OEN_RST;
         clk_cfg_r.sys_from_pll   <= !rcfg_pkg::BYPASS_RST;
         clk_cfg_r.div_used       <= rcfg_pkg::USEDIV_RST;
         clk_cfg_r.div_code       <= rcfg_pkg::SYSTEM_DIVISOR_FIELD_RST;
         clk_cfg_r.osc_sel        <= rcfg_pkg::OSC_RST;
      end else begin
         clk_cfg_r.pll_power_down <= pll_power_down_bit_r;
         clk_cfg_r.pll_out_en     <= !oen_r;
         clk_cfg_r.sys_from_pll   <= pll_path;
         clk_cfg_r.div_used       <= usediv_r || pll_path;
         clk_cfg_r.div_code       <= div_nxt;
         clk_cfg_r.osc_sel        <= osc_r;
      end
   end

   // The PLL wants the quartered internal oscillator; flag when it has it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_ok_r <= 1'b0;
      end else begin
         osc_ok_r <= (osc_r == rcfg_pkg::OSC_INT_QTR);
      end
   end

   // Gating set choice follows the power mode, steered by auto gating.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gating_r <= rcfg_pkg::RCFG_RUN;
      end else begin
         case (power_mode)
            rcfg_pkg::RCFG_RUN:   gating_r <= rcfg_pkg::RCFG_RUN;
            rcfg_pkg::RCFG_SLEEP: gating_r <= acg_r ? rcfg_pkg::RCFG_SLEEP
                                                    : rcfg_pkg::RCFG_RUN;
            rcfg_pkg::RCFG_DEEP:  gating_r <= acg_r ? rcfg_pkg::RCFG_DEEP
                                                    : rcfg_pkg::RCFG_RUN;
            default:              gating_r <= rcfg_pkg::RCFG_RUN;
         endcase
      end
   end

   assign clk_cfg        = clk_cfg_r;
   assign gating_select  = gating_r;
   assign osc_pll_src_ok = osc_ok_r;

   // ----------------------------------------------------------------
   // System clock enable
   // ----------------------------------------------------------------

   // Code n divides by n plus one; the pulse models the divided clock in
   // pclk cycles, since the real PLL clock never enters this block.
   assign ratio = {1'b0, clk_cfg_r.div_code} + rcfg_pkg::DIV_RATIO_OFS;

   rcfg_div_tick i_rcfg_div_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (clk_cfg_r.div_used),
      .ratio   (ratio),
      .tick    (sys_clk_en)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   a_pin_clears_others: assert property (
      @(posedge pclk) disable iff (!presetn)
      (phase_r == rcfg_pkg::RCFG_PH_CAPTURE) && reset_cause.pin_reset_flag
      |=> origin_r == rcfg_pkg::ORIGIN_PIN
   ) else $error("pin reset did not leave only the pin flag");

   a_causes_accumulate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (phase_r == rcfg_pkg::RCFG_PH_CAPTURE) && !reset_cause.pin_reset_flag
      |=> origin_r == ($past(origin_r) | $past(cause_bits))
   ) else $error("reset cause flags did not accumulate");

   a_origin_write_stores: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_origin && (phase_r == rcfg_pkg::RCFG_PH_RUN)
      |=> origin_r == $past(pwdata[rcfg_pkg::ORIGIN_MSB:0])
   ) else $error("origin write not stored");

   a_sleep_gating_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      (power_mode == rcfg_pkg::RCFG_SLEEP) && !wr_clock
      |=> gating_select == (acg_r ? rcfg_pkg::RCFG_SLEEP : rcfg_pkg::RCFG_RUN)
   ) else $error("sleep gating set wrong");

   a_run_gating_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      power_mode == rcfg_pkg::RCFG_RUN |=> gating_select == rcfg_pkg::RCFG_RUN
   ) else $error("run mode left the run gating set");

   a_divisor_floor: assert property (
      @(posedge pclk) disable iff (!presetn)
      clk_cfg.sys_from_pll |-> clk_cfg.div_code >= MIN_DIV_CODE
   ) else $error("PLL divisor below minimum");

   a_divisor_forced: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_clock && !pwdata[rcfg_pkg::BYPASS_BIT] |=> ##1 clk_cfg.div_used
   ) else $error("PLL selected without divisor");

   a_powerdown_follows: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_clock |=> ##1 clk_cfg.pll_power_down == $past(pwdata[rcfg_pkg::PLL_POWER_DOWN_BIT_BIT], 2)
   ) else $error("PLL power-down does not follow its bit");

   a_output_enable_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_clock |=> ##1 clk_cfg.pll_out_en == !$past(pwdata[rcfg_pkg::OEN_BIT], 2)
   ) else $error("PLL output driver not active-low enabled");

   a_pll_tick_spacing: assert property (
      @(posedge pclk) disable iff (!presetn)
      sys_clk_en && clk_cfg.div_used && !wr_clock && !$past(wr_clock)
      |=> !sys_clk_en || $changed(clk_cfg.div_code) || !clk_cfg.div_used
   ) else $error("divided clock enable pulsed too often");

   a_reserved_read_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_clock
      |=> (prdata & 32'hf03f_c7cf) == 32'h0000_0000
   ) else $error("reserved clock bits read nonzero");

   a_osc_reserved_kept: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_clock && pwdata[rcfg_pkg::OSC_MSB:rcfg_pkg::OSC_LSB] == rcfg_pkg::OSC_RESERVED
      |=> osc_r == $past(osc_r)
   ) else $error("reserved oscillator code was taken");

   a_deep_gating_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      (power_mode == rcfg_pkg::RCFG_DEEP) && !wr_clock
      |=> gating_select == (acg_r ? rcfg_pkg::RCFG_DEEP : rcfg_pkg::RCFG_RUN)
   ) else $error("deep-sleep gating set wrong");

   a_bypass_selects: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_clock |=> ##1 clk_cfg.sys_from_pll == !$past(pwdata[rcfg_pkg::BYPASS_BIT], 2)
   ) else $error("system clock source does not follow the skip bit");

   a_origin_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_origin
      |=> prdata == {26'h0, $past(origin_r)}
   ) else $error("origin flags read back wrong");

endmodule // rcfg_ctrl

// File: reset_cause_and_clock_config_bench.sv
`timescale 1ns/100ps

module reset_cause_and_clock_config_bench;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic                  pclk;
   logic                  presetn;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [11:0]           paddr;
   logic [31:0]           pwdata;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   rcfg_pkg::rcfg_cause_t reset_cause;
   rcfg_pkg::rcfg_mode_t  power_mode;
   rcfg_pkg::rcfg_clk_t   clk_cfg;
   rcfg_pkg::rcfg_mode_t  gating_select;
   logic                  osc_pll_src_ok;
   logic                  sys_clk_en;
   logic [31:0]           rd;
   logic                  err;
   logic [5:0]            acc;
   int                    err_total;
   int                    tests_run;
   int                    gap_len;

   rcfg_ctrl i_rcfg_ctrl (
      .pclk           (pclk),
      .presetn        (presetn),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .reset_cause    (reset_cause),
      .power_mode     (power_mode),
      .clk_cfg        (clk_cfg),
      .gating_select  (gating_select),
      .osc_pll_src_ok (osc_pll_src_ok),
      .sys_clk_en     (sys_clk_en)
   );

   // 25 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Prints the verdict and ends the run from one place.
   task automatic conclude();
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Compares a seen value with an expected one and counts both outcomes.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; an idle edge follows so that psel never toggles twice in a step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int k;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      e = pslverr;
      if (pready !== 1'b1) begin
         err_total++;
         conclude();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, err);
      repeat (2) @(posedge pclk);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000, rd, err);
      check(rd, exp);
   endtask

   // Applies a reset with the given cause held across the release edge.
   task automatic rst(input logic [5:0] cause);
      reset_cause <= cause;
      presetn     <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn     <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   // Measures the spacing of two system clock enable pulses, bounded.
   task automatic gap(output int c);
      int k;
      k = 0;
      while (sys_clk_en !== 1'b1 && k < 40) begin
         @(posedge pclk);
         k++;
      end
      if (sys_clk_en !== 1'b1) begin
         err_total++;
         conclude();
      end
      @(posedge pclk);
      c = 1;
      while (sys_clk_en !== 1'b1 && c < 40) begin
         @(posedge pclk);
         c++;
      end
      if (sys_clk_en !== 1'b1) begin
         err_total++;
         conclude();
      end
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   // A global bound cuts a hang short and still reaches the verdict.
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      conclude();
   end

   initial begin
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 12'h000;
      pwdata      = 32'h0000_0000;
      reset_cause = 6'h03;
      power_mode  = rcfg_pkg::RCFG_RUN;
      err_total   = 0;
      tests_run   = 0;
      rst(6'h03);
      rdchk(rcfg_pkg::OFS_RESET_ORIGIN, 32'h0000_0001);
      rdchk(rcfg_pkg::OFS_RUN_CLOCK, 32'h0780_3800);
      check({22'h0, clk_cfg}, 32'h0000_023c);
      // Reserved bits must not stick; flags must.
      wr(rcfg_pkg::OFS_RESET_ORIGIN, 32'hffff_ffff);
      rdchk(rcfg_pkg::OFS_RESET_ORIGIN, 32'h0000_003f);
      wr(rcfg_pkg::OFS_RESET_ORIGIN, 32'h0000_0000);
      rdchk(rcfg_pkg::OFS_RESET_ORIGIN, 32'h0000_0000);
      // Non-pin causes, power-on included, pile up across successive resets.
      acc = 6'h00;
      for (int i = 1; i < 6; i++) begin
         rst(6'h01 << i);
         acc = acc | (6'h01 << i);
         rdchk(rcfg_pkg::OFS_RESET_ORIGIN, {26'h0, acc});
      end
      rst(6'h3d);
      rdchk(rcfg_pkg::OFS_RESET_ORIGIN, 32'h0000_0001);
      // Reserved clock bits ignored; bypass path with divisor 0xa.
      wr(rcfg_pkg::OFS_RUN_CLOCK, 32'hfd7f_c810);
      rdchk(rcfg_pkg::OFS_RUN_CLOCK, 32'h0d40_0810);
      check({22'h0, clk_cfg}, 32'h0000_0169);
      gap(gap_len);
      check(gap_len, 32'd11);
      // Gating set per mode, with auto gating on and then off.
      for (int g = 1; g >= 0; g--) begin
         wr(rcfg_pkg::OFS_RUN_CLOCK, 32'h0540_0810 | (32'(g) << rcfg_pkg::ACG_BIT));
         for (int m = 0; m < 3; m++) begin
            power_mode <= rcfg_pkg::rcfg_mode_t'(m);
            repeat (3) @(posedge pclk);
            check({30'h0, gating_select}, (g == 1) ? 32'(m) : 32'h0);
         end
      end
      power_mode <= rcfg_pkg::RCFG_RUN;
      // Every legal oscillator code, then the reserved one keeps the last.
      for (int o = 0; o < 4; o++) begin
         wr(rcfg_pkg::OFS_RUN_CLOCK, 32'h0780_3800 | (32'(o) << 4));
         check({30'h0, clk_cfg.osc_sel}, (o == 3) ? 32'h2 : 32'(o));
         check({31'h0, osc_pll_src_ok}, (o >= 2) ? 32'h1 : 32'h0);
      end
      // PLL in use with a too-low divisor: clamped, divisor forced on.
      wr(rcfg_pkg::OFS_RUN_CLOCK, 32'h0180_0000);
      check({22'h0, clk_cfg}, {22'h0, 4'h7, rcfg_pkg::MIN_DIV_DFLT, 2'h0});
      gap(gap_len);
      check(gap_len, 32'(rcfg_pkg::MIN_DIV_DFLT) + 32'd1);
      wr(rcfg_pkg::OFS_RUN_CLOCK, 32'h0600_0000);
      check({22'h0, clk_cfg}, 32'h0000_01f0);
      // Powered down with output enabled but bypassed: no divisor in use.
      wr(rcfg_pkg::OFS_RUN_CLOCK, 32'h0000_2800);
      check({22'h0, clk_cfg}, 32'h0000_0300);
      // An unmapped word answers with an error and reads zero.
      apb(1'b1, 12'h064, 32'hffff_ffff, rd, err);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 12'h064, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0000);
      rdchk(rcfg_pkg::OFS_RUN_CLOCK, 32'h0000_2800);
      conclude();
   end

endmodule // reset_cause_and_clock_config_bench
